/* avsm_slave_config.sv */
`timescale 1ns/1ps
// Mode control, configuration and link address register for the voltage scaling slave.
module avsm_slave_config (
    input  wire logic                 clk_in,                 // Core clock, 20 MHz.
    input  wire logic                 rst_n_in,               // Power-on reset, active low.
    input  wire logic                 link_clk_in,            // Link clock from the bus master.
    input  wire logic                 link_commit_in,         // Commit write strobe, link domain.
    input  wire logic [15:0]          link_commit_data_in,    // Commit voltage word, link domain.
    input  wire logic                 strap_enable_in,        // Stored voltage_scaling_enable.
    input  wire logic                 strap_startup_in,       // Stored startup_hold_bit.
    input  wire logic                 other_channel_scale_in, // Other channel is in scaling mode.
    input  wire logic                 cmd_write_in,           // Management write strobe.
    input  wire logic [7:0]           cmd_code_in,            // Management command code.
    input  wire logic [15:0]          cmd_data_in,            // Management write data.
    input  wire logic                 alert_clear_in,         // Clears the fault and alert.
    output logic [15:0]               cmd_rdata_out,          // Read data for cmd_code_in.
    output avsm_pkg::avsm_mode_t      mode_out,               // Current operating mode.
    output logic [3:0]                link_device_address_out,// Address answered on the link.
    output logic [1:0]                payload_code_out,       // Voltage word length code.
    output logic                      slew_slow_out,          // High selects 2 mV per 30 us.
    output logic [15:0]               vref_target_out,        // Last accepted voltage word.
    output logic                      vref_update_out,        // One cycle per accepted commit.
    output logic [15:0]               read_frame_voltage_out, // Voltage word for read frames.
    output logic                      other_fault_out,        // Sticky other-fault flag.
    output logic                      smbalert_n_out          // Alert line, active low.
);
    import avsm_pkg::*;

    // Configuration bits.
    logic       double_commit_check_reg;
    logic [1:0] payload_reg;
    logic       slew_reg;
    logic       enable_reg;
    logic       hold_reg;
    logic [3:0] link_device_address_reg;

    // Strap synchronisers and power-up sampling.
    logic [1:0] strap_sync1_reg;
    logic [1:0] strap_sync2_reg;
    logic [1:0] settle_reg;
    logic       sampled_reg;
    avsm_mode_t mode_reg;
    avsm_mode_t mode_next;

    // Decoded writes.
    logic       wr_cfg;
    logic       wr_addr;
    logic       addr_blocked;
    logic       fault_set;

    // Link crossing.
    avsm_link_cfg_t link_cfg_sync1_reg;
    avsm_link_cfg_t link_cfg_sync2_reg;
    avsm_link_cfg_t core_link_cfg;
    logic           link_toggle;
    logic [15:0]    link_data;
    logic [2:0]     toggle_sync_reg;

    assign wr_cfg       = cmd_write_in && (cmd_code_in == AVSM_CMD_CONFIG);
    assign wr_addr      = cmd_write_in && (cmd_code_in == AVSM_CMD_LINK_ADDRESS);
    // Startup adjust counts as scaling for the address lock.
    assign addr_blocked = (mode_reg != AVSM_MODE_HOST) && other_channel_scale_in;
    assign fault_set    = wr_addr && addr_blocked;

    // Straps come from stored configuration outside this clock, so they are synchronised.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            strap_sync1_reg <= 2'h0;
            strap_sync2_reg <= 2'h0;
        end else begin
            strap_sync1_reg <= {strap_enable_in, strap_startup_in};
            strap_sync2_reg <= strap_sync1_reg;
        end
    end

    // Wait until the synchronisers hold real strap values before sampling once.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            settle_reg  <= 2'h0;
            sampled_reg <= 1'b0;
        end else if (settle_reg != AVSM_STRAP_SETTLE) begin
            settle_reg <= settle_reg + 2'h1;
        end else begin
            sampled_reg <= 1'b1;
        end
    end

    // Configuration register; enable and hold load from the straps once after power up.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            double_commit_check_reg <= 1'b0;
            payload_reg             <= AVSM_PAYLOAD_RESET;
            slew_reg                <= 1'b0;
            enable_reg              <= 1'b0;
            hold_reg                <= 1'b0;
        end else if (!sampled_reg && (settle_reg == AVSM_STRAP_SETTLE)) begin
            enable_reg <= strap_sync2_reg[1];
            hold_reg   <= strap_sync2_reg[0];
        end else if (wr_cfg) begin
            double_commit_check_reg <= cmd_data_in[AVSM_CFG_CHECK_BIT];
            payload_reg             <= cmd_data_in[AVSM_CFG_PAYLOAD_LSB +: 2];
            slew_reg                <= cmd_data_in[AVSM_CFG_SLEW_BIT];
            enable_reg              <= cmd_data_in[AVSM_CFG_ENABLE_BIT];
            hold_reg                <= cmd_data_in[AVSM_CFG_HOLD_BIT];
        end
    end

    // Mode selection; enable changes matter only for leaving startup adjust, otherwise at the next power cycle.
    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            AVSM_MODE_HOST: begin
                mode_next = AVSM_MODE_HOST;
            end
            AVSM_MODE_SCALE: begin
                if (hold_reg) begin
                    mode_next = AVSM_MODE_STARTUP;
                end
            end
            AVSM_MODE_STARTUP: begin
                if (enable_reg && !hold_reg) begin
                    mode_next = AVSM_MODE_SCALE;
                end
            end
            default: begin
                mode_next = AVSM_MODE_HOST;
            end
        endcase
    end

    // Mode register; the power-up sample happens exactly once per reset.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_reg <= AVSM_MODE_HOST;
        end else if (!sampled_reg && (settle_reg == AVSM_STRAP_SETTLE)) begin
            if (!strap_sync2_reg[1]) begin
                mode_reg <= AVSM_MODE_HOST;
            end else if (strap_sync2_reg[0]) begin
                mode_reg <= AVSM_MODE_STARTUP;
            end else begin
                mode_reg <= AVSM_MODE_SCALE;
            end
        end else if (sampled_reg) begin
            mode_reg <= mode_next;
        end
    end

    // Link address register; only the low nibble exists.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            link_device_address_reg <= AVSM_ADDR_RESET;
        end else if (wr_addr && !addr_blocked) begin
            link_device_address_reg <= cmd_data_in[3:0];
        end
    end

    // Sticky fault and alert; a new fault wins over a clear in the same cycle.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            other_fault_out <= 1'b0;
            smbalert_n_out  <= 1'b1;
        end else if (fault_set) begin
            other_fault_out <= 1'b1;
            smbalert_n_out  <= 1'b0;
        end else if (alert_clear_in) begin
            other_fault_out <= 1'b0;
            smbalert_n_out  <= 1'b1;
        end
    end

    // Read data; reserved bits return zero.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cmd_rdata_out <= 16'h0000;
        end else begin
            case (cmd_code_in)
                AVSM_CMD_LINK_ADDRESS: begin
                    cmd_rdata_out <= {12'h000, link_device_address_reg};
                end
                AVSM_CMD_CONFIG: begin
                    cmd_rdata_out <= {10'h000, enable_reg, hold_reg, double_commit_check_reg,
                                      payload_reg, slew_reg};
                end
                AVSM_CMD_STATUS: begin
                    cmd_rdata_out <= {13'h0000, other_fault_out, mode_reg};
                end
                default: begin
                    cmd_rdata_out <= 16'h0000;
                end
            endcase
        end
    end

    // Configuration outputs mirror the registers.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_out                <= AVSM_MODE_HOST;
            link_device_address_out <= AVSM_ADDR_RESET;
            payload_code_out        <= AVSM_PAYLOAD_RESET;
            slew_slow_out           <= 1'b0;
        end else begin
            mode_out                <= mode_reg;
            link_device_address_out <= link_device_address_reg;
            payload_code_out        <= payload_reg;
            slew_slow_out           <= slew_reg;
        end
    end

    // Quasi-static configuration into the link domain. A multi-bit level is safe here
    // only because software keeps these bits still while scaling runs.
    assign core_link_cfg = '{double_commit_check: double_commit_check_reg, payload: payload_reg};
    always_ff @(posedge link_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            link_cfg_sync1_reg <= '{double_commit_check: 1'b0, payload: AVSM_PAYLOAD_RESET};
            link_cfg_sync2_reg <= '{double_commit_check: 1'b0, payload: AVSM_PAYLOAD_RESET};
        end else begin
            link_cfg_sync1_reg <= core_link_cfg;
            link_cfg_sync2_reg <= link_cfg_sync1_reg;
        end
    end

    avsm_commit_filter u_filter (
        .link_clk_in (link_clk_in),
        .rst_n_in    (rst_n_in),
        .cfg_in      (link_cfg_sync2_reg),
        .commit_in   (link_commit_in),
        .data_in     (link_commit_data_in),
        .toggle_out  (link_toggle),
        .data_out    (link_data)
    );

    // Accepted commits cross by toggle; the word is held stable on the link side until
    // the next accepted commit, so commits must be a few core cycles apart.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            toggle_sync_reg <= 3'h0;
        end else begin
            toggle_sync_reg <= {toggle_sync_reg[1:0], link_toggle};
        end
    end

    // Capture the accepted word and pulse the update.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            vref_target_out <= 16'h0000;
            vref_update_out <= 1'b0;
        end else begin
            vref_update_out <= toggle_sync_reg[2] ^ toggle_sync_reg[1];
            if (toggle_sync_reg[2] ^ toggle_sync_reg[1]) begin
                vref_target_out <= link_data;
            end
        end
    end

    // Read frames carry the voltage at the selected payload width.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            read_frame_voltage_out <= 16'h0000;
        end else begin
            read_frame_voltage_out <= vref_target_out & avsm_payload_mask(payload_reg);
        end
    end

endmodule

/* avsm_pkg.sv */
// Overview of operation
// - Double commit check resets off; when on, a commit applies only after an identical repeat.
// - Payload code 00/01/10/11 selects 8 (reserved), 10 (default), 12 or 16 bit voltage.
// - The payload length sets voltage width both sent in reads and expected in writes.
// - Slew select resets to fast 200 mV per 30 us; one selects slow 2 mV per 30 us.
// - At power cycle mode comes from enable and startup hold bits; otherwise host mode stays.
// - Scaling mode enters startup adjust when hold bit set; clearing it returns immediately if enable is set.
// - A 4 bit device and channel address sits in bits 3:0 of a 16 bit register.
// - Address write while both channels scale is acknowledged, not stored, sets fault and alert.
// - With only one channel scaling, address writes are stored normally.
package avsm_pkg;

    // Command codes on the management port.
    localparam logic [7:0]  AVSM_CMD_LINK_ADDRESS = 8'hEA;
    localparam logic [7:0]  AVSM_CMD_CONFIG       = 8'hE9;
    localparam logic [7:0]  AVSM_CMD_STATUS       = 8'hEE;

    // Configuration register field positions.
    localparam int          AVSM_CFG_SLEW_BIT     = 0;
    localparam int          AVSM_CFG_PAYLOAD_LSB  = 1;
    localparam int          AVSM_CFG_CHECK_BIT    = 3;
    localparam int          AVSM_CFG_HOLD_BIT     = 4;
    localparam int          AVSM_CFG_ENABLE_BIT   = 5;

    // Reset values and strap settle count.
    localparam logic [3:0]  AVSM_ADDR_RESET       = 4'h5;
    localparam logic [1:0]  AVSM_PAYLOAD_RESET    = 2'h1;
    localparam logic [1:0]  AVSM_STRAP_SETTLE     = 2'h3;

    // Payload codes.
    localparam logic [1:0]  AVSM_PAYLOAD_8        = 2'h0;
    localparam logic [1:0]  AVSM_PAYLOAD_10       = 2'h1;
    localparam logic [1:0]  AVSM_PAYLOAD_12       = 2'h2;
    localparam logic [1:0]  AVSM_PAYLOAD_16       = 2'h3;

    // Operating modes, Gray coded along host, scaling, startup adjust.
    typedef enum logic [1:0] {
        AVSM_MODE_HOST    = 2'h0,
        AVSM_MODE_SCALE   = 2'h1,
        AVSM_MODE_STARTUP = 2'h3
    } avsm_mode_t;

    // Link facing configuration carried across the clock boundary.
    typedef struct packed {
        logic       double_commit_check;
        logic [1:0] payload;
    } avsm_link_cfg_t;

    // Voltage word mask for a payload code.
    function automatic logic [15:0] avsm_payload_mask(input logic [1:0] code);
        case (code)
            AVSM_PAYLOAD_8:  avsm_payload_mask = 16'h00FF;
            AVSM_PAYLOAD_10: avsm_payload_mask = 16'h03FF;
            AVSM_PAYLOAD_12: avsm_payload_mask = 16'h0FFF;
            default:         avsm_payload_mask = 16'hFFFF;
        endcase
    endfunction

endpackage

/* avsm_commit_filter.sv */
`timescale 1ns/1ps
// Link side commit filter: applies the double commit check and payload width.
module avsm_commit_filter (
    input  wire logic                    link_clk_in,   // Link clock.
    input  wire logic                    rst_n_in,      // Asynchronous reset, active low.
    input  wire avsm_pkg::avsm_link_cfg_t cfg_in,       // Synchronised configuration.
    input  wire logic                    commit_in,     // Commit write strobe from master.
    input  wire logic [15:0]             data_in,       // Commit write voltage word.
    output logic                         toggle_out,    // Toggles once per accepted commit.
    output logic [15:0]                  data_out       // Accepted voltage word.
);
    import avsm_pkg::*;

    logic        pending_reg;
    logic [15:0] pending_data_reg;
    logic [15:0] masked;

    // Only the payload width of the word is meaningful.
    assign masked = data_in & avsm_payload_mask(cfg_in.payload);

    // Pair tracking; an unmatched commit becomes the new first of a pair.
    always_ff @(posedge link_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pending_reg      <= 1'b0;
            pending_data_reg <= 16'h0000;
        end else if (commit_in) begin
            if (!cfg_in.double_commit_check) begin
                pending_reg <= 1'b0;
            end else if (pending_reg && (pending_data_reg == masked)) begin
                pending_reg <= 1'b0;
            end else begin
                pending_reg      <= 1'b1;
                pending_data_reg <= masked;
            end
        end
    end

    // Accepted commits hold their word and toggle the crossing flag.
    always_ff @(posedge link_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            toggle_out <= 1'b0;
            data_out   <= 16'h0000;
        end else if (commit_in && (!cfg_in.double_commit_check ||
                     (pending_reg && (pending_data_reg == masked)))) begin
            toggle_out <= ~toggle_out;
            data_out   <= masked;
        end
    end

endmodule

/* avsm_slave_config_props.sv */
`timescale 1ns/1ps
// Port-level checks of the block's rules.
module avsm_slave_config_props (
    input wire logic                 clk_in,                  // Core clock.
    input wire logic                 rst_n_in,                // Reset, active low.
    input wire logic                 other_channel_scale_in,  // Other channel scaling.
    input wire logic                 cmd_write_in,            // Write strobe.
    input wire logic [7:0]           cmd_code_in,             // Command code.
    input wire logic [15:0]          cmd_data_in,             // Write data.
    input wire logic [15:0]          cmd_rdata_out,           // Read data.
    input wire avsm_pkg::avsm_mode_t mode_out,                // Mode.
    input wire logic [3:0]           link_device_address_out, // Link address.
    input wire logic [1:0]           payload_code_out,        // Payload code.
    input wire logic                 slew_slow_out,           // Slew select.
    input wire logic [15:0]          vref_target_out,         // Accepted word.
    input wire logic                 vref_update_out,         // Commit pulse.
    input wire logic                 other_fault_out,         // Fault flag.
    input wire logic                 smbalert_n_out           // Alert, active low.
);
    import avsm_pkg::*;
    // Edges since reset release, saturating, so checks can skip the strap load window.
    logic [3:0] cnt_reg;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_reg <= 4'h0;
        end else if (cnt_reg != 4'h8) begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
    // Startup adjust counts as scaling for the address lock.
    wire logic wr_addr = cmd_write_in && (cmd_code_in == AVSM_CMD_LINK_ADDRESS);
    wire logic locked  = other_channel_scale_in && (mode_out != AVSM_MODE_HOST);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_lock_fault; wr_addr && locked |=> other_fault_out && !smbalert_n_out; endproperty
    a_lock_fault: assert property (p_lock_fault) else $error("fault missing after locked write");
    property p_lock_keep; wr_addr && locked |=> ##1 $stable(link_device_address_out); endproperty
    a_lock_keep: assert property (p_lock_keep) else $error("locked address changed");
    property p_store; wr_addr && !locked |-> ##2 link_device_address_out == $past(cmd_data_in[3:0], 2); endproperty
    a_store: assert property (p_store) else $error("address write not stored");
    property p_upper_zero; cmd_code_in == AVSM_CMD_LINK_ADDRESS |=> cmd_rdata_out[15:4] == 12'h000; endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("reserved address bits not zero");
    property p_reset_vals; cnt_reg == 4'h1 |-> payload_code_out == 2'h1 && !slew_slow_out && link_device_address_out == 4'h5; endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("wrong value after reset");
    property p_host_holds; cnt_reg == 4'h8 && $past(mode_out) == AVSM_MODE_HOST |-> mode_out == AVSM_MODE_HOST; endproperty
    a_host_holds: assert property (p_host_holds) else $error("host mode left without reset");
    property p_pulse; vref_update_out |=> !vref_update_out [*3]; endproperty
    a_pulse: assert property (p_pulse) else $error("commit pulse too long");
    property p_width12; vref_update_out && payload_code_out == AVSM_PAYLOAD_12 |-> vref_target_out[15:12] == 4'h0; endproperty
    a_width12: assert property (p_width12) else $error("word wider than payload");
endmodule
bind avsm_slave_config avsm_slave_config_props u_avsm_slave_config_props (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .other_channel_scale_in(other_channel_scale_in),
    .cmd_write_in(cmd_write_in), .cmd_code_in(cmd_code_in), .cmd_data_in(cmd_data_in),
    .cmd_rdata_out(cmd_rdata_out), .mode_out(mode_out), .link_device_address_out(link_device_address_out),
    .payload_code_out(payload_code_out), .slew_slow_out(slew_slow_out), .vref_target_out(vref_target_out),
    .vref_update_out(vref_update_out), .other_fault_out(other_fault_out), .smbalert_n_out(smbalert_n_out));

/* avsm_link_master.sv */
`timescale 1ns/1ps
// Bus master model; the link clock runs only within a frame.
module avsm_link_master (
    output logic        link_clk_out, // Link clock, 12 ns period, idle low.
    output logic        commit_out,   // Commit write strobe.
    output logic [15:0] data_out      // Commit voltage word.
);
    // Idle lines start quiet with a word the bench never commits.
    initial begin
        link_clk_out = 1'b0;
        commit_out = 1'b0;
        data_out = 16'h5A5A;
    end
    // Lines change after a falling edge; off the commit cycle the word is inverted so a late sample fails.
    task automatic send(input logic [15:0] word, input logic strobe);
        #3;
        for (int i = 0; i < 6; i++) begin
            #6 link_clk_out = 1'b1;
            #6 link_clk_out = 1'b0;
            commit_out = strobe && (i == 1);
            data_out = (i == 1) ? word : ~data_out;
        end
    endtask
endmodule

/* avsm_slave_config_bench.sv */
`timescale 1ns/1ps
// Directed bench; each scenario judges its own result.
module avsm_slave_config_bench;
    import avsm_pkg::*;
    logic        clk_in, rst_n_in, link_clk_in, link_commit_in, strap_enable_in, strap_startup_in;
    logic        other_channel_scale_in, cmd_write_in, alert_clear_in, slew_slow_out, vref_update_out;
    logic        other_fault_out, smbalert_n_out;
    logic [1:0]  payload_code_out;
    logic [3:0]  link_device_address_out;
    logic [7:0]  cmd_code_in;
    logic [15:0] link_commit_data_in, cmd_data_in, cmd_rdata_out, vref_target_out, read_frame_voltage_out;
    avsm_mode_t  mode_out;
    int          n_mismatch, cmp_count;
    avsm_link_master u_avsm_link_master (.link_clk_out(link_clk_in), .commit_out(link_commit_in),
        .data_out(link_commit_data_in));
    avsm_slave_config u_avsm_slave_config (.clk_in(clk_in), .rst_n_in(rst_n_in), .link_clk_in(link_clk_in),
        .link_commit_in(link_commit_in), .link_commit_data_in(link_commit_data_in),
        .strap_enable_in(strap_enable_in), .strap_startup_in(strap_startup_in),
        .other_channel_scale_in(other_channel_scale_in), .cmd_write_in(cmd_write_in), .cmd_code_in(cmd_code_in),
        .cmd_data_in(cmd_data_in), .alert_clear_in(alert_clear_in), .cmd_rdata_out(cmd_rdata_out),
        .mode_out(mode_out), .link_device_address_out(link_device_address_out),
        .payload_code_out(payload_code_out), .slew_slow_out(slew_slow_out), .vref_target_out(vref_target_out),
        .vref_update_out(vref_update_out), .read_frame_voltage_out(read_frame_voltage_out),
        .other_fault_out(other_fault_out), .smbalert_n_out(smbalert_n_out));
    // Core clock, 50 ns period.
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    // Counts every comparison and reports a difference at once.
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Power cycle with the given stored bits; the link clock runs an idle frame while reset is held low.
    task automatic do_reset(input logic en, input logic st);
        @(negedge clk_in);
        rst_n_in = 1'b0;
        strap_enable_in = en;
        strap_startup_in = st;
        u_avsm_link_master.send(16'h0000, 1'b0);
        repeat (5) @(negedge clk_in);
        rst_n_in = 1'b1;
        repeat (8) @(negedge clk_in);
    endtask
    // One write, then time for the configuration outputs to follow.
    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        @(negedge clk_in);
        cmd_write_in = 1'b1;
        cmd_code_in = code;
        cmd_data_in = data;
        @(negedge clk_in);
        cmd_write_in = 1'b0;
        repeat (3) @(negedge clk_in);
    endtask
    task automatic rd(input logic [7:0] code, input logic [15:0] exp);
        @(negedge clk_in);
        cmd_code_in = code;
        @(negedge clk_in);
        chk("cmd_rdata_out", exp, cmd_rdata_out);
    endtask
    task automatic wait_mode(input avsm_mode_t exp);
        for (int i = 0; i < 10 && mode_out !== exp; i++) @(negedge clk_in);
        chk("mode_out", {14'h0000, exp}, {14'h0000, mode_out});
        if (mode_out !== exp) finish_test();
    endtask
    // Sends one commit; hit says whether an update pulse must follow, exp is the word then held.
    task automatic commit(input logic [15:0] word, input logic hit, input logic [15:0] exp);
        logic seen;
        seen = 1'b0;
        u_avsm_link_master.send(word, 1'b1);
        for (int i = 0; i < 12 && !seen; i++) begin
            @(negedge clk_in);
            seen = (vref_update_out === 1'b1);
        end
        @(negedge clk_in);
        chk("vref_update_out", {15'h0000, hit}, {15'h0000, seen});
        chk("vref_target_out", exp, vref_target_out);
        chk("read_frame_voltage_out", exp, read_frame_voltage_out);
        if (hit && !seen) finish_test();
    endtask
    task automatic t_power_modes();
        do_reset(1'b0, 1'b1);
        wait_mode(AVSM_MODE_HOST);
        wr(AVSM_CMD_CONFIG, 16'h0032);
        repeat (10) @(negedge clk_in);
        wait_mode(AVSM_MODE_HOST);
        other_channel_scale_in = 1'b1;
        wr(AVSM_CMD_LINK_ADDRESS, 16'h0007);
        chk("link_device_address_out", 16'h0007, {12'h000, link_device_address_out});
        other_channel_scale_in = 1'b0;
        do_reset(1'b1, 1'b1);
        wait_mode(AVSM_MODE_STARTUP);
        do_reset(1'b1, 1'b0);
        wait_mode(AVSM_MODE_SCALE);
        chk("payload_code_out", 16'h0001, {14'h0000, payload_code_out});
        chk("slew_slow_out", 16'h0000, {15'h0000, slew_slow_out});
        rd(AVSM_CMD_LINK_ADDRESS, 16'h0005);
        $display("test power_modes done");
    endtask
    // Upper bits are dropped; with both channels scaling the write is refused and flagged.
    task automatic t_address();
        wr(AVSM_CMD_LINK_ADDRESS, 16'hFFF3);
        rd(AVSM_CMD_LINK_ADDRESS, 16'h0003);
        other_channel_scale_in = 1'b1;
        wr(AVSM_CMD_LINK_ADDRESS, 16'h0009);
        chk("link_device_address_out", 16'h0003, {12'h000, link_device_address_out});
        chk("fault_alert", 16'h0002, {14'h0000, other_fault_out, smbalert_n_out});
        rd(AVSM_CMD_STATUS, 16'h0005);
        other_channel_scale_in = 1'b0;
        alert_clear_in = 1'b1;
        @(negedge clk_in);
        alert_clear_in = 1'b0;
        @(negedge clk_in);
        chk("fault_alert", 16'h0001, {14'h0000, other_fault_out, smbalert_n_out});
        $display("test address done");
    endtask
    // Every allowed payload code, longest first, with slow slew on the 12 bit pass.
    task automatic t_payload();
        logic [15:0] mask [1:3] = '{16'h03FF, 16'h0FFF, 16'hFFFF};
        do_reset(1'b0, 1'b0);
        for (int p = 3; p >= 1; p--) begin
            wr(AVSM_CMD_CONFIG, {10'h000, 1'b0, 1'b0, 1'b0, p[1:0], p == 2});
            chk("payload_code_out", 16'(p), {14'h0000, payload_code_out});
            chk("slew_slow_out", {15'h0000, p == 2}, {15'h0000, slew_slow_out});
            commit(16'hABCD, 1'b1, 16'hABCD & mask[p]);
        end
        $display("test payload done");
    endtask
    // Double check on: a differing second word replaces the pending one; a repeat applies it.
    task automatic t_double();
        wr(AVSM_CMD_CONFIG, 16'h000A);
        commit(16'h0123, 1'b0, 16'h03CD);
        commit(16'h0155, 1'b0, 16'h03CD);
        commit(16'h0155, 1'b1, 16'h0155);
        $display("test double done");
    endtask
    task automatic t_modes();
        do_reset(1'b1, 1'b0);
        wr(AVSM_CMD_CONFIG, 16'h0032);
        wait_mode(AVSM_MODE_STARTUP);
        wr(AVSM_CMD_CONFIG, 16'h0022);
        wait_mode(AVSM_MODE_SCALE);
        $display("test modes done");
    endtask
    initial begin
        n_mismatch = 0;
        cmp_count = 0;
        rst_n_in = 1'b0;
        {strap_enable_in, strap_startup_in, other_channel_scale_in, cmd_write_in, alert_clear_in} = 5'h00;
        cmd_code_in = 8'h00;
        cmd_data_in = 16'h0000;
        t_power_modes();
        t_address();
        t_payload();
        t_double();
        t_modes();
        finish_test();
    end
endmodule
